/* hdl/wcs_counter.v */
// one 16-bit watchpoint event counter with its compare value
`timescale 1ns/100ps
`default_nettype none
`include "wcs_defs.vh"

module wcs_counter (
  // clock and reset
  input  wire                   CORE_CLK,
  input  wire                   RST_N,
  // control
  input  wire                   enable,
  input  wire                   incr,
  // register write
  input  wire                   wr_en,
  input  wire [`WCS_DW-1:0]     wr_data,
  // state
  output reg  [`WCS_CW-1:0]     count_ff,
  output reg  [`WCS_CW-1:0]     match_ff,
  output wire                   hit
);

  reg [`WCS_CW-1:0] nxt_count;
  reg [`WCS_CW-1:0] nxt_match;

  always @*
  begin
    nxt_count = count_ff;
    nxt_match = match_ff;
    if (wr_en)
    begin
      nxt_count = wr_data[`WCS_COUNT_HI:`WCS_COUNT_LO];
      nxt_match = wr_data[`WCS_MATCH_HI:`WCS_MATCH_LO];
    end
    // count assigned watchpoints, hold when disabled
    else if (enable && incr)
    begin
      nxt_count = count_ff + `WCS_CNT_ONE;
    end
  end

  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      count_ff <= `WCS_CNT_RST;
      match_ff <= `WCS_CNT_RST;
    end
    else
    begin
      count_ff <= nxt_count;
      match_ff <= nxt_match;
    end
  end

  // asserted only while enabled and equal
  assign hit = enable && (count_ff == match_ff);

endmodule // wcs_counter

`default_nettype wire

/* hdl/wcs_watch_stop.v */
// watchpoint breakpoint mode, event counters and exception halt select
`timescale 1ns/100ps
`default_nettype none
`include "wcs_defs.vh"

module wcs_watch_stop (
  // clock and reset
  input  wire                     CORE_CLK,
  input  wire                     RST_N,
  // special-register move port from the core
  input  wire                     SPR_SUPV,
  input  wire                     SPR_WE,
  input  wire                     SPR_RE,
  input  wire [`WCS_SEL_W-1:0]    SPR_SEL,
  input  wire [`WCS_DW-1:0]       SPR_WDATA,
  output reg  [`WCS_DW-1:0]       SPR_RDATA,
  // development interface register port
  input  wire                     DBG_WE,
  input  wire                     DBG_RE,
  input  wire [`WCS_SEL_W-1:0]    DBG_SEL,
  input  wire [`WCS_DW-1:0]       DBG_WDATA,
  output reg  [`WCS_DW-1:0]       DBG_RDATA,
  // watchpoints from the comparator chain and chain settings
  input  wire [`WCS_NMATCH-1:0]   WATCH_IN,
  input  wire [1:0]               CHAIN_WP8,
  input  wire [1:0]               CHAIN_WP9,
  // breakpoint to the core
  output reg                      BREAK_TRAP,
  output reg  [`WCS_NWP-1:0]      WATCH_OUT,
  // exception classes raised by the core
  input  wire [`WCS_NEXC-1:0]     EXC_RAISE,
  output reg                      HALT_REQ,
  output reg  [`WCS_NEXC-1:0]     HALT_CLASS,
  output reg  [`WCS_NEXC-1:0]     EXC_NORMAL
);

  // one-hot decode of a register select, shared by both ports
  function [3:0] sel_decode;
    input [`WCS_SEL_W-1:0] sel;
    begin
      sel_decode = 4'h0;
      case (sel)
        `WCS_SEL_MODE: sel_decode = 4'h1;
        `WCS_SEL_CNT0: sel_decode = 4'h2;
        `WCS_SEL_CNT1: sel_decode = 4'h4;
        `WCS_SEL_HALT: sel_decode = 4'h8;
        default:       sel_decode = 4'h0;
      endcase
    end
  endfunction

  // chain a counter match with its partner watchpoint
  function chain_wp;
    input [1:0] mode;
    input       cnt_hit;
    input       partner;
    begin
      case (mode)
        `WCS_CHAIN_AND: chain_wp = cnt_hit & partner;
        `WCS_CHAIN_OR:  chain_wp = cnt_hit | partner;
        // reserved code behaves as the plain match
        default:        chain_wp = cnt_hit;
      endcase
    end
  endfunction

  // read word for a select, shared by both ports so they never disagree
  function [`WCS_DW-1:0] rd_word;
    input [`WCS_SEL_W-1:0] sel;
    input [`WCS_DW-1:0]    mode_word;
    input [`WCS_DW-1:0]    cnt0_word;
    input [`WCS_DW-1:0]    cnt1_word;
    input [`WCS_DW-1:0]    halt_word;
    begin
      case (sel)
        `WCS_SEL_MODE: rd_word = mode_word;
        `WCS_SEL_CNT0: rd_word = cnt0_word;
        `WCS_SEL_CNT1: rd_word = cnt1_word;
        `WCS_SEL_HALT: rd_word = halt_word;
        // unmapped selects read zero rather than alias a register
        default:       rd_word = `WCS_DATA_ZERO;
      endcase
    end
  endfunction

  // register state
  reg  [`WCS_NCNT-1:0]   ce_ff;
  reg  [`WCS_NWP-1:0]    assign_ff;
  reg  [`WCS_NWP-1:0]    src_ff;
  reg  [`WCS_NWP-1:0]    cause_ff;
  reg  [`WCS_NEXC-1:0]   halt_ff;
  reg  [`WCS_NCNT-1:0]   nxt_ce;
  reg  [`WCS_NWP-1:0]    nxt_assign;
  reg  [`WCS_NWP-1:0]    nxt_src;
  reg  [`WCS_NWP-1:0]    nxt_cause;
  reg  [`WCS_NEXC-1:0]   nxt_halt;
  reg  [`WCS_DW-1:0]     nxt_spr_rdata;
  reg  [`WCS_DW-1:0]     nxt_dbg_rdata;

  // counter state
  wire [`WCS_CW-1:0]     cnt_count [0:`WCS_NCNT-1];
  wire [`WCS_CW-1:0]     cnt_match [0:`WCS_NCNT-1];
  wire [`WCS_NCNT-1:0]   cnt_hit;
  wire [`WCS_NCNT-1:0]   cnt_wr;
  wire [`WCS_NCNT-1:0]   cnt_inc;

  // watchpoint and access decode
  wire [3:0]             spr_wsel;
  wire [3:0]             dbg_wsel;
  wire                   spr_wr_ok;
  wire                   spr_rd_ok;
  wire                   wp8;
  wire                   wp9;
  wire [`WCS_NWP-1:0]    wp_all;
  wire [`WCS_NWP-1:0]    wp_fire;
  wire                   mode_wr;
  wire [`WCS_DW-1:0]     mode_wdata;
  wire                   halt_wr;
  wire [`WCS_DW-1:0]     halt_wdata;
  wire [`WCS_DW-1:0]     cnt_wdata [0:`WCS_NCNT-1];
  wire [`WCS_DW-1:0]     mode_rd;
  wire [`WCS_DW-1:0]     halt_rd;

  // moves only honoured in supervisor mode
  assign spr_wr_ok = SPR_WE && SPR_SUPV;
  assign spr_rd_ok = SPR_RE && SPR_SUPV;

  assign spr_wsel = spr_wr_ok ? sel_decode(SPR_SEL) : 4'h0;
  assign dbg_wsel = DBG_WE ? sel_decode(DBG_SEL) : 4'h0;

  // either party may write; debug port wins a collision
  assign mode_wr    = spr_wsel[0] | dbg_wsel[0];
  assign mode_wdata = dbg_wsel[0] ? DBG_WDATA : SPR_WDATA;
  // halt select writable from both sides
  assign halt_wr    = spr_wsel[3] | dbg_wsel[3];
  assign halt_wdata = dbg_wsel[3] ? DBG_WDATA : SPR_WDATA;

  // counter watchpoints 8 and 9 with their chaining
  assign wp8 = chain_wp(CHAIN_WP8, cnt_hit[0], WATCH_IN[`WCS_WP_CHAIN0]);
  assign wp9 = chain_wp(CHAIN_WP9, cnt_hit[1], WATCH_IN[`WCS_WP_CHAIN1]);
  assign wp_all = {wp9, wp8, WATCH_IN};

  // only enabled sources raise a breakpoint
  // source bit 8 is the counter zero watchpoint
  assign wp_fire = wp_all & src_ff;

  genvar gi;
  generate
    for (gi = 0; gi < `WCS_NCNT; gi = gi + 1)
    begin : g_cnt
      // clear map bit feeds counter zero, set feeds one
      if (gi == 0)
      begin : g_zero
        assign cnt_inc[gi] = |(wp_all & ~assign_ff);
      end
      else
      begin : g_one
        assign cnt_inc[gi] = |(wp_all & assign_ff);
      end
      assign cnt_wr[gi]    = spr_wsel[gi+1] | dbg_wsel[gi+1];
      assign cnt_wdata[gi] = dbg_wsel[gi+1] ? DBG_WDATA : SPR_WDATA;

      wcs_counter u_cnt (
        .CORE_CLK (CORE_CLK),
        .RST_N    (RST_N),
        .enable   (ce_ff[gi]),
        .incr     (cnt_inc[gi]),
        .wr_en    (cnt_wr[gi]),
        .wr_data  (cnt_wdata[gi]),
        .count_ff (cnt_count[gi]),
        .match_ff (cnt_match[gi]),
        .hit      (cnt_hit[gi])
      );
    end
  endgenerate

  // register next state
  always @*
  begin
    nxt_ce     = ce_ff;
    nxt_assign = assign_ff;
    nxt_src    = src_ff;
    nxt_cause  = cause_ff;
    nxt_halt   = halt_ff;
    if (mode_wr)
    begin
      nxt_ce     = {mode_wdata[`WCS_CE1_BIT], mode_wdata[`WCS_CE0_BIT]};
      nxt_assign = mode_wdata[`WCS_ASSIGN_HI:`WCS_ASSIGN_LO];
      nxt_src    = mode_wdata[`WCS_SRC_HI:`WCS_SRC_LO];
      // a written zero clears, a written one keeps
      nxt_cause  = cause_ff & mode_wdata[`WCS_CAUSE_HI:`WCS_CAUSE_LO];
    end
    // record every watchpoint behind the breakpoint
    // cause bit 8 stands for counter zero
    // a new cause wins over a clear in the same cycle
    nxt_cause = nxt_cause | wp_fire;
    // reserved bits above 13 are not stored
    if (halt_wr)
    begin
      nxt_halt = halt_wdata[`WCS_HALT_HI:`WCS_HALT_LO];
    end
  end

  assign mode_rd = {cause_ff, src_ff, assign_ff, ce_ff[1], ce_ff[0]};
  assign halt_rd = {{`WCS_RSV_W{1'b0}}, halt_ff};

  // read muxes; unmapped selects and refused moves return zero
  always @*
  begin
    nxt_spr_rdata = `WCS_DATA_ZERO;
    nxt_dbg_rdata = `WCS_DATA_ZERO;
    if (spr_rd_ok)
    begin
      nxt_spr_rdata = rd_word(SPR_SEL, mode_rd,
                              {cnt_match[0], cnt_count[0]},
                              {cnt_match[1], cnt_count[1]},
                              halt_rd);
    end
    if (DBG_RE)
    begin
      nxt_dbg_rdata = rd_word(DBG_SEL, mode_rd,
                              {cnt_match[0], cnt_count[0]},
                              {cnt_match[1], cnt_count[1]},
                              halt_rd);
    end
  end

  // state and registered outputs
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ce_ff      <= `WCS_CE_RST;
      assign_ff  <= `WCS_MAP_RST;
      src_ff     <= `WCS_MAP_RST;
      cause_ff   <= `WCS_MAP_RST;
      // every halt bit clears at reset
      halt_ff    <= `WCS_HALT_RST;
      SPR_RDATA  <= `WCS_DATA_ZERO;
      DBG_RDATA  <= `WCS_DATA_ZERO;
      BREAK_TRAP <= 1'b0;
      WATCH_OUT  <= `WCS_MAP_RST;
      HALT_REQ   <= 1'b0;
      HALT_CLASS <= `WCS_HALT_RST;
      EXC_NORMAL <= `WCS_HALT_RST;
    end
    else
    begin
      ce_ff      <= nxt_ce;
      assign_ff  <= nxt_assign;
      src_ff     <= nxt_src;
      cause_ff   <= nxt_cause;
      halt_ff    <= nxt_halt;
      SPR_RDATA  <= nxt_spr_rdata;
      DBG_RDATA  <= nxt_dbg_rdata;
      // trap whenever an enabled watchpoint fires
      BREAK_TRAP <= |wp_fire;
      WATCH_OUT  <= wp_all;
      // selected classes hand over to the debugger
      HALT_REQ   <= |(EXC_RAISE & halt_ff);
      HALT_CLASS <= EXC_RAISE & halt_ff;
      // unselected classes go to their handler
      EXC_NORMAL <= EXC_RAISE & ~halt_ff;
    end
  end

endmodule // wcs_watch_stop

`default_nettype wire

/* inc/wcs_defs.vh */
// constants for the watchpoint counter and exception halt block
`ifndef WCS_DEFS_VH
`define WCS_DEFS_VH

// register select codes on the special-register and debug ports
`define WCS_SEL_W         4
`define WCS_SEL_MODE      4'h0
`define WCS_SEL_CNT0      4'h1
`define WCS_SEL_CNT1      4'h2
`define WCS_SEL_HALT      4'h3

// register width and watchpoint counts
`define WCS_DW            32
`define WCS_NWP           10
`define WCS_NMATCH        8
`define WCS_NCNT          2
`define WCS_NEXC          14

// watch_break_mode field positions
`define WCS_CE0_BIT       0
`define WCS_CE1_BIT       1
`define WCS_ASSIGN_LO     2
`define WCS_ASSIGN_HI     11
`define WCS_SRC_LO        12
`define WCS_SRC_HI        21
`define WCS_CAUSE_LO      22
`define WCS_CAUSE_HI      31

// watch_event_counter field positions
`define WCS_COUNT_LO      0
`define WCS_COUNT_HI      15
`define WCS_MATCH_LO      16
`define WCS_MATCH_HI      31
`define WCS_CW            16

// exception_halt_select field positions
`define WCS_HALT_LO       0
`define WCS_HALT_HI       13
`define WCS_RSV_W         18

// watchpoint numbers fed by the counters and their chain partners
`define WCS_WP_CNT0       8
`define WCS_WP_CNT1       9
`define WCS_WP_CHAIN0     3
`define WCS_WP_CHAIN1     7

// chain codes for the counter-derived watchpoints
`define WCS_CHAIN_PLAIN   2'h0
`define WCS_CHAIN_AND     2'h1
`define WCS_CHAIN_OR      2'h2

// reset values
`define WCS_CE_RST        2'h0
`define WCS_MAP_RST       10'h000
`define WCS_HALT_RST      14'h0000
`define WCS_CNT_RST       16'h0000
`define WCS_CNT_ONE       16'h0001
`define WCS_DATA_ZERO     32'h00000000

`endif

/* verif/wcs_core_model.sv */
// core and debug-port model issuing register moves
`timescale 1ns/100ps
`default_nettype none
module wcs_core_model (
  // clock
  input wire logic        CORE_CLK,
  // core move port
  output logic            SPR_SUPV,
  output logic            SPR_WE,
  output logic            SPR_RE,
  output logic [3:0]      SPR_SEL,
  output logic [31:0]     SPR_WDATA,
  input wire logic [31:0] SPR_RDATA,
  // debug port
  output logic            DBG_WE,
  output logic            DBG_RE,
  output logic [3:0]      DBG_SEL,
  output logic [31:0]     DBG_WDATA,
  input wire logic [31:0] DBG_RDATA
);
  initial
  begin
    {SPR_SUPV, SPR_WE, SPR_RE, DBG_WE, DBG_RE} = 5'h00;
    {SPR_SEL, DBG_SEL, SPR_WDATA, DBG_WDATA} = 72'h0;
  end
  task automatic acc(input bit dbg, input bit sv, input bit we, input [3:0] sel,
                     input [31:0] wd, output logic [31:0] rd);
    @(posedge CORE_CLK);
    SPR_SUPV <= sv;
    {SPR_WE, SPR_RE} <= {we, !we} & {2{!dbg}};
    {DBG_WE, DBG_RE} <= {we, !we} & {2{dbg}};
    {SPR_SEL, DBG_SEL, SPR_WDATA, DBG_WDATA} <= {sel, sel, wd, wd};
    @(posedge CORE_CLK);
    {SPR_WE, SPR_RE, DBG_WE, DBG_RE} <= 4'h0;
    // released lines flip so stale data never looks valid
    {SPR_SEL, DBG_SEL, SPR_WDATA, DBG_WDATA} <= ~{sel, sel, wd, wd};
    #1 rd = dbg ? DBG_RDATA : SPR_RDATA;
  endtask
endmodule // wcs_core_model
`default_nettype wire

/* verif/wcs_watch_stop_props.sv */
// port assertions for the watch, read and halt paths
`timescale 1ns/100ps
`default_nettype none
module wcs_watch_stop_props (
  // clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  // register ports
  input wire logic        SPR_SUPV,
  input wire logic        SPR_WE,
  input wire logic        SPR_RE,
  input wire logic [31:0] SPR_RDATA,
  input wire logic        DBG_WE,
  input wire logic        DBG_RE,
  input wire logic [3:0]  DBG_SEL,
  input wire logic [31:0] DBG_WDATA,
  input wire logic [31:0] DBG_RDATA,
  // watch and halt
  input wire logic [7:0]  WATCH_IN,
  input wire logic [9:0]  WATCH_OUT,
  input wire logic        BREAK_TRAP,
  input wire logic [13:0] EXC_RAISE,
  input wire logic        HALT_REQ,
  input wire logic [13:0] HALT_CLASS,
  input wire logic [13:0] EXC_NORMAL
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_exc_all_routed: assert property ((HALT_CLASS | EXC_NORMAL) == $past(EXC_RAISE))
    else $error("raised class lost");
  a_halt_disjoint: assert property ((HALT_CLASS & EXC_NORMAL) == 14'h0)
    else $error("class both halted and normal");
  a_halt_req_any: assert property (HALT_REQ == (|HALT_CLASS))
    else $error("halt request mismatch");
  a_watch_copy: assert property (WATCH_OUT[7:0] == $past(WATCH_IN))
    else $error("watch copy wrong");
  a_trap_has_watch: assert property (BREAK_TRAP |-> WATCH_OUT != 10'h0)
    else $error("trap without watchpoint");
  a_user_read_zero: assert property (SPR_RE && !SPR_SUPV |=> SPR_RDATA == 32'h0)
    else $error("user read returned data");
  a_read_idle_zero: assert property (!DBG_RE |=> DBG_RDATA == 32'h0)
    else $error("read data without strobe");
  a_unmapped_zero: assert property (DBG_RE && DBG_SEL > 4'h3 |=> DBG_RDATA == 32'h0)
    else $error("unmapped read nonzero");
  a_halt_rsvd_zero: assert property (DBG_RE && DBG_SEL == 4'h3 |=> DBG_RDATA[31:14] == 18'h0)
    else $error("reserved halt bits set");
  a_halt_write_back: assert property ((DBG_WE && DBG_SEL == 4'h3) ##1 !(DBG_WE || SPR_WE)
    ##1 (DBG_RE && DBG_SEL == 4'h3 && !(DBG_WE || SPR_WE))
    |=> DBG_RDATA[13:0] == $past(DBG_WDATA[13:0], 3)) else $error("halt select readback");
endmodule // wcs_watch_stop_props
bind wcs_watch_stop wcs_watch_stop_props u_props (.*);
`default_nettype wire

/* verif/wcs_watch_stop_tb_top.sv */
// self-checking bench for the watchpoint counter and halt block
`timescale 1ns/100ps
`default_nettype none
`include "wcs_defs.vh"
module wcs_watch_stop_tb_top;
  logic        CORE_CLK, RST_N, SPR_SUPV, SPR_WE, SPR_RE, DBG_WE, DBG_RE;
  logic        BREAK_TRAP, HALT_REQ;
  logic [3:0]  SPR_SEL, DBG_SEL;
  logic [31:0] SPR_WDATA, DBG_WDATA, SPR_RDATA, DBG_RDATA, seed, rd, h;
  logic [7:0]  WATCH_IN, w;
  logic [1:0]  CHAIN_WP8, CHAIN_WP9;
  logic [9:0]  WATCH_OUT, src, cause;
  logic [13:0] EXC_RAISE, HALT_CLASS, EXC_NORMAL, e;
  int          n_errors, cmp_count;
  wcs_watch_stop uut (.*);
  wcs_core_model u_core (.*);
  initial
  begin
    CORE_CLK = 1'b0;
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  function automatic [31:0] nxt_rand(input [31:0] s);
    nxt_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [31:0] mode_word(input [9:0] c, s, m, input [1:0] ce);
    mode_word = {c, s, m, ce};
  endfunction
  task automatic chk(input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input bit d, input [3:0] s, input [31:0] x);
    u_core.acc(d, 1'b1, 1'b1, s, x, rd);
  endtask
  task automatic rc(input bit d, input [3:0] s, input [31:0] x);
    u_core.acc(d, 1'b1, 1'b0, s, 32'h0, rd);
    chk(rd, x);
  endtask
  task automatic pulse(input [7:0] x, input int n);
    repeat (n)
    begin
      @(posedge CORE_CLK);
      WATCH_IN <= x;
      @(posedge CORE_CLK);
      WATCH_IN <= 8'h00;
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {RST_N, WATCH_IN, CHAIN_WP8, CHAIN_WP9, EXC_RAISE} = 27'h0;
    {seed, cause, n_errors, cmp_count} = {32'd96598, 10'h0, 64'h0};
    repeat (10) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    for (int s = 4; s < 16; s++)
      wr(1'b1, s[3:0], 32'hffffffff);
    for (int s = 0; s < 16; s++)
      rc(1'b1, s[3:0], 32'h0);
    u_core.acc(1'b0, 1'b0, 1'b1, `WCS_SEL_CNT0, 32'h5, rd);
    u_core.acc(1'b0, 1'b0, 1'b0, `WCS_SEL_CNT0, 32'h0, rd);
    rc(1'b1, `WCS_SEL_CNT0, 32'h0);
    $display("test registers done");
    h = nxt_rand(seed) & 32'h00003fff;
    wr(1'b1, `WCS_SEL_HALT, nxt_rand(seed));
    rc(1'b1, `WCS_SEL_HALT, h);
    rc(1'b0, `WCS_SEL_HALT, h);
    for (int i = 0; i < 20; i++)
    begin
      seed = nxt_rand(seed);
      e = (i == 0) ? 14'h000f : seed[13:0];
      @(posedge CORE_CLK);
      EXC_RAISE <= e;
      @(posedge CORE_CLK);
      EXC_RAISE <= 14'h0;
      #1 chk(HALT_CLASS, e & h[13:0]);
    end
    $display("test halt done");
    for (int i = 0; i < 12; i++)
    begin
      seed = nxt_rand(seed);
      src = (i == 0) ? 10'h0 : {2'b00, seed[7:0]};
      w = seed[15:8] | {8{i == 0}};
      wr(1'b1, `WCS_SEL_MODE, mode_word(10'h3ff, src, 10'h0, 2'b00));
      pulse(w, 1);
      #1 chk(BREAK_TRAP, |(w & src[7:0]));
      cause = cause | {2'b00, w & src[7:0]};
    end
    rc(1'b1, `WCS_SEL_MODE, mode_word(cause, src, 10'h0, 2'b00));
    wr(1'b0, `WCS_SEL_MODE, mode_word(10'h0, src, 10'h0, 2'b00));
    rc(1'b0, `WCS_SEL_MODE, mode_word(10'h0, src, 10'h0, 2'b00));
    $display("test break done");
    wr(1'b1, `WCS_SEL_MODE, mode_word(10'h0, 10'h100, 10'h102, 2'b01));
    wr(1'b1, `WCS_SEL_CNT0, {16'd3, 16'd0});
    wr(1'b0, `WCS_SEL_CNT1, {16'd2, 16'd0});
    pulse(8'h03, 3);
    @(posedge CORE_CLK);
    #1 chk({BREAK_TRAP, WATCH_OUT}, 11'h500);
    rc(1'b1, `WCS_SEL_CNT0, {16'd3, 16'd3});
    rc(1'b1, `WCS_SEL_CNT1, {16'd2, 16'd0});
    rc(1'b1, `WCS_SEL_MODE, mode_word(10'h100, 10'h100, 10'h102, 2'b01));
    for (int c = 0; c < 4; c++)
    begin
      @(posedge CORE_CLK);
      {CHAIN_WP8, CHAIN_WP9} <= {c[1:0], c[1:0]};
      @(posedge CORE_CLK);
      #1 chk(WATCH_OUT, {1'b0, c != 1, 8'h00});
    end
    @(posedge CORE_CLK);
    CHAIN_WP8 <= 2'h0;
    wr(1'b1, `WCS_SEL_MODE, mode_word(10'h0, 10'h200, 10'h102, 2'b10));
    pulse(8'h02, 2);
    @(posedge CORE_CLK);
    #1 chk(WATCH_OUT, 10'h200);
    rc(1'b1, `WCS_SEL_CNT0, {16'd3, 16'd3});
    $display("test counters done");
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    n_errors++;
    close_out();
  end
endmodule // wcs_watch_stop_tb_top
`default_nettype wire
